// >>> include/pdc_pkg.sv
// shared constants and carrier types of the preprocessed channel block
package pdc_pkg;

    // =====================================================
    // geometry
    localparam int SLOT_W  = 5;               // 32 line timeslots
    localparam int PAIR_W  = SLOT_W - 1;      // timeslot pairs
    localparam int LANE_W  = 12;              // code[11:8], data[7:0]
    localparam int LANES   = 4;               // entries per pair
    localparam int QDEPTH  = 8;               // change address queue
    localparam int QPTR_W  = 3;

    // =====================================================
    // register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_PERIOD = 8'h04;
    localparam logic [7:0] REG_CMSEL  = 8'h08;
    localparam logic [7:0] REG_CMDATA = 8'h0C;
    localparam logic [7:0] REG_QUEUE  = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;

    // field positions
    localparam int CTRL_HS_BIT    = 0;        // handshake protocol on
    localparam int CTRL_TRI_BIT   = 1;        // tristate lsbs upstream
    localparam int CTRL_INIT_BIT  = 2;        // start memory reset
    localparam int STAT_BUSY_BIT  = 0;
    localparam int STAT_OVF_BIT   = 1;
    localparam int QUEUE_VLD_BIT  = 8;

    // reset values
    localparam logic       HS_RST     = 1'b1;
    localparam logic       TRI_RST    = 1'b0;
    localparam logic [7:0] PERIOD_RST = 8'h00;

    // =====================================================
    // entry lanes inside one pair word, index {up, odd}
    localparam logic [1:0] LANE_DN_EVEN = 2'h0;
    localparam logic [1:0] LANE_DN_ODD  = 2'h1;
    localparam logic [1:0] LANE_UP_EVEN = 2'h2;
    localparam logic [1:0] LANE_UP_ODD  = 2'h3;

    // control memory codes
    localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
    localparam logic [3:0] CODE_SW64       = 4'h1;
    localparam logic [1:0] CODE_SW16_TOP   = 2'h1;  // 01xx selects pair
    localparam logic [3:0] CODE_CI_UP      = 4'h8;
    localparam logic [3:0] CODE_SIGNAL     = 4'hA;
    localparam logic [3:0] CODE_DN_OFF     = 4'hB;

    // =====================================================
    // carriers
    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        logic [7:0]        rx;                // byte from the line card
        logic [7:0]        mon_tx;            // monitor byte to send
        logic              mr;                // handler receive ack
        logic              mx;                // handler transmit ack
    } pdc_slot_t;

    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        logic [7:0]        data;
        logic [7:0]        oe;                // per-bit drive enable
    } pdc_line_tx_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] ptr;                      // pcm timeslot pointer
        logic [7:0] data;
        logic [7:0] oe;
    } pdc_pcm_up_t;

    typedef struct packed {
        logic              valid;
        logic [SLOT_W-1:0] slot;
        logic [7:0]        data;
    } pdc_mon_rx_t;

endpackage

// >>> src/pdc_cmem.sv
// connection control memory with lane writes and registered read
`timescale 1ns/1ps
module pdc_cmem #(
    parameter int ADDR_W = 4,
    parameter int LANE_W = 12,
    parameter int LANES  = 4
) (
    input  wire logic                    core_clk,  // core clock
    input  wire logic                    reset,     // async, high
    input  wire logic                    rd_en,     // read strobe
    input  wire logic [ADDR_W-1:0]       rd_addr,   // read pair
    output      logic [LANES*LANE_W-1:0] rd_data,   // registered data
    input  wire logic [LANES-1:0]        wr_lanes,  // lane enables
    input  wire logic [ADDR_W-1:0]       wr_addr,   // write pair
    input  wire logic [LANES*LANE_W-1:0] wr_data    // write data
);

    // =====================================================
    // one memory column and one read register per lane, so that
    // no storage word is written from more than one process
    for (genvar l = 0; l < LANES; l++) begin : g_lane
        logic [LANE_W-1:0] mem [2**ADDR_W];
        logic [LANE_W-1:0] rd_q;

        // lane write
        always_ff @(posedge core_clk)
        begin
            if (wr_lanes[l])
                mem[wr_addr] <= wr_data[l*LANE_W +: LANE_W];
        end

        // read data out of a register
        always_ff @(posedge core_clk or posedge reset)
        begin
            if (reset)
                rd_q <= '0;
            else if (rd_en)
                rd_q <= mem[rd_addr];
        end

        assign rd_data[l*LANE_W +: LANE_W] = rd_q;
    end

endmodule

// >>> src/pdc_core.sv
// preprocessed d-channel and signaling pair handler
`timescale 1ns/1ps
module pdc_core
    import pdc_pkg::*;
(
    input  wire logic         core_clk,     // 200 MHz core clock
    input  wire logic         reset,        // async reset, high
    input  wire logic         wb_cyc_i,     // bus cycle
    input  wire logic         wb_stb_i,     // bus strobe
    input  wire logic         wb_we_i,      // bus write
    input  wire logic [7:0]   wb_adr_i,     // byte address
    input  wire logic [3:0]   wb_sel_i,     // byte enables
    input  wire logic [31:0]  wb_dat_i,     // write data
    output      logic [31:0]  wb_dat_o,     // read data
    output      logic         wb_ack_o,     // bus acknowledge
    input  wire logic         frame_start,  // one pulse per frame
    input  wire pdc_slot_t    slot_in,      // timeslot from line side
    output      logic [7:0]   pcm_dn_ptr,   // pcm slot lookup address
    input  wire logic [7:0]   pcm_dn_byte,  // byte at pcm_dn_ptr
    output      pdc_line_tx_t line_tx,      // byte to line side
    output      pdc_pcm_up_t  pcm_up,       // byte to pcm side
    output      pdc_mon_rx_t  mon_rx,       // monitor byte to handler
    output      logic         change_irq    // change queue not empty
);

    typedef struct packed {
        logic                  hs_mode;
        logic                  tri_lsb;
        logic [7:0]            period;
        logic [PAIR_W+1:0]     cm_sel;      // {up, pair, odd}
        logic                  init_busy;
        logic [PAIR_W-1:0]     init_ptr;
        logic [7:0]            frame_cnt;
        logic                  smp;
        logic                  p1_v;
        logic                  p1_smp;
        pdc_slot_t             p1;
        pdc_line_tx_t          tx;
        pdc_pcm_up_t           up;
        pdc_mon_rx_t           mon;
        logic [QDEPTH-1:0][SLOT_W-1:0] q;
        logic [QPTR_W-1:0]     wp;
        logic [QPTR_W-1:0]     rp;
        logic [QPTR_W:0]       cnt;
        logic                  ovf;
        logic                  ack;
        logic [31:0]           dat;
        logic                  rd_wait;
    } pdc_state_t;

    pdc_state_t st;
    pdc_state_t next_st;

    logic                    rd_en;
    logic [PAIR_W-1:0]       rd_addr;
    logic [LANES*LANE_W-1:0] rd_data;
    logic [LANES-1:0]        wr_lanes;
    logic [PAIR_W-1:0]       wr_addr;
    logic [LANES*LANE_W-1:0] wr_data;
    logic [LANE_W-1:0]       de, dd, ue, uo;
    logic [1:0]              hs;
    logic [2:0]              dpos, upos;
    logic                    push;
    logic                    bus_req;
    logic [1:0]              sel_lane;

    // =====================================================
    // memory and its lane views
    pdc_cmem #(
        .ADDR_W (PAIR_W),
        .LANE_W (LANE_W),
        .LANES  (LANES)
    ) u_cmem (
        .core_clk (core_clk),
        .reset    (reset),
        .rd_en    (rd_en),
        .rd_addr  (rd_addr),
        .rd_data  (rd_data),
        .wr_lanes (wr_lanes),
        .wr_addr  (wr_addr),
        .wr_data  (wr_data)
    );

    assign de = rd_data[LANE_DN_EVEN*LANE_W +: LANE_W];
    assign dd = rd_data[LANE_DN_ODD*LANE_W +: LANE_W];
    assign ue = rd_data[LANE_UP_EVEN*LANE_W +: LANE_W];
    assign uo = rd_data[LANE_UP_ODD*LANE_W +: LANE_W];
    assign dpos = {dd[9:8], 1'b0};
    assign upos = {uo[9:8], 1'b0};
    assign hs = st.hs_mode ? {st.p1.mr, st.p1.mx}
                           : 2'b11;
    assign bus_req  = wb_cyc_i & wb_stb_i & ~st.ack;
    assign sel_lane = {st.cm_sel[PAIR_W+1], st.cm_sel[0]};

    // outputs
    assign pcm_dn_ptr = dd[7:0];
    assign line_tx    = st.tx;
    assign pcm_up     = st.up;
    assign mon_rx     = st.mon;
    assign wb_ack_o   = st.ack;
    assign wb_dat_o   = st.dat;
    assign change_irq = (st.cnt != '0);

    // =====================================================
    // next state
    always_comb
    begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.tx.valid = 1'b0;
        next_st.up.valid = 1'b0;
        next_st.mon.valid = 1'b0;
        rd_en = 1'b0;
        rd_addr = slot_in.slot[SLOT_W-1:1];
        wr_lanes = '0;
        wr_addr = st.p1.slot[SLOT_W-1:1];
        wr_data = '0;
        push = 1'b0;

        // last look period in frames
        if (frame_start)
        begin
            if (st.frame_cnt >= st.period)
            begin
                next_st.frame_cnt = '0;
                next_st.smp = 1'b1;
            end
            else
            begin
                next_st.frame_cnt = st.frame_cnt + 8'h01;
                next_st.smp = 1'b0;
            end
        end

        // stage 0: take slot, read pair entries on odd slots
        next_st.p1_v = slot_in.valid;
        next_st.p1 = slot_in;
        next_st.p1_smp = st.smp;
        if (slot_in.valid && slot_in.slot[0])
            rd_en = 1'b1;

        // stage 1, even slot: monitor channel to and from handler
        if (st.p1_v && !st.p1.slot[0])
        begin
            next_st.mon = '{1'b1, st.p1.slot, st.p1.rx};
            next_st.tx = '{1'b1, st.p1.slot, st.p1.mon_tx, 8'hFF};
        end

        // stage 1, odd slot: downstream build
        if (st.p1_v && st.p1.slot[0])
        begin
            next_st.tx = '{1'b1, st.p1.slot, 8'h00, 8'h00};
            if (dd[11:8] == CODE_SW64)
            begin
                next_st.tx.data = {pcm_dn_byte[7:2],
                                   pcm_dn_byte[1:0] & hs};
                next_st.tx.oe = 8'hFF;
            end
            else
            begin
                if (de[11:8] == CODE_SIGNAL || de[11:8] == CODE_CI_UP)
                begin
                    next_st.tx.data[5:0] = {de[5:2], de[1:0] & hs};
                    next_st.tx.oe[5:0] = 6'h3F;
                    if (de[11:8] == CODE_SIGNAL && dd[11:8] == CODE_DN_OFF)
                    begin
                        next_st.tx.data[7:6] = de[7:6];
                        next_st.tx.oe[7:6] = 2'b11;
                    end
                end
                if (dd[11:10] == CODE_SW16_TOP)
                begin
                    next_st.tx.data[7:6] = 2'(pcm_dn_byte >> dpos);
                    next_st.tx.oe[7:6] = 2'b11;
                end
                // code 1011 leaves the D bits undriven unless the even entry holds code 1010
            end

            // upstream towards pcm
            next_st.up.ptr = uo[7:0];
            if (uo[11:8] == CODE_SW64)
            begin
                next_st.up.valid = 1'b1;
                next_st.up.data = st.p1.rx;
                next_st.up.oe = {6'h3F, {2{~st.tri_lsb}}};
            end
            else if (uo[11:10] == CODE_SW16_TOP)
            begin
                next_st.up.valid = 1'b1;
                next_st.up.data = 8'({6'h00, st.p1.rx[7:6]} << upos);
                next_st.up.oe = 8'(8'h03 << upos);
            end
            // code 0000 sends nothing upstream

            // command field change against previous frame
            if (ue[11:8] == CODE_CI_UP && st.p1.rx[5:2] != ue[5:2])
            begin
                wr_lanes[LANE_UP_EVEN] = 1'b1;
                wr_data[LANE_UP_EVEN*LANE_W +: LANE_W] =
                    {ue[11:6], st.p1.rx[5:2], ue[1:0]};
                push = 1'b1;
            end

            // double last look on the signaling field
            if (ue[11:8] == CODE_SIGNAL && uo[11:8] == CODE_SIGNAL
                && st.p1_smp)
            begin
                wr_lanes[LANE_UP_EVEN] = 1'b1;
                wr_data[LANE_UP_EVEN*LANE_W +: LANE_W] =
                    {ue[11:8], st.p1.rx[7:2], ue[1:0]};
                if (st.p1.rx[7:2] == ue[7:2] && st.p1.rx[7:2] != uo[7:2])
                begin
                    wr_lanes[LANE_UP_ODD] = 1'b1;
                    wr_data[LANE_UP_ODD*LANE_W +: LANE_W] =
                        {uo[11:8], st.p1.rx[7:2], uo[1:0]};
                    push = 1'b1;
                end
            end
        end

        // memory reset sweep when the port is free
        if (st.init_busy && wr_lanes == '0)
        begin
            wr_lanes = '1;
            wr_addr = st.init_ptr;
            wr_data = {LANES{CODE_UNASSIGNED, 8'h00}};
            next_st.init_ptr = st.init_ptr + 1'b1;
            if (st.init_ptr == '1)
                next_st.init_busy = 1'b0;
        end

        // bus slave
        if (bus_req)
        begin
            next_st.dat = '0;
            unique case (wb_adr_i)
                REG_CTRL:
                begin
                    if (wb_we_i && wb_sel_i[0])
                    begin
                        next_st.hs_mode = wb_dat_i[CTRL_HS_BIT];
                        next_st.tri_lsb = wb_dat_i[CTRL_TRI_BIT];
                        if (wb_dat_i[CTRL_INIT_BIT])
                        begin
                            next_st.init_busy = 1'b1;
                            next_st.init_ptr = '0;
                        end
                    end
                    next_st.dat[CTRL_HS_BIT] = st.hs_mode;
                    next_st.dat[CTRL_TRI_BIT] = st.tri_lsb;
                    next_st.ack = 1'b1;
                end
                REG_PERIOD:
                begin
                    if (wb_we_i && wb_sel_i[0])
                        next_st.period = wb_dat_i[7:0];
                    next_st.dat[7:0] = st.period;
                    next_st.ack = 1'b1;
                end
                REG_CMSEL:
                begin
                    if (wb_we_i && wb_sel_i[0])
                        next_st.cm_sel = wb_dat_i[PAIR_W+1:0];
                    next_st.dat[PAIR_W+1:0] = st.cm_sel;
                    next_st.ack = 1'b1;
                end
                REG_CMDATA:
                begin
                    if (wb_we_i)
                    begin
                        if (wr_lanes == '0 && !st.init_busy)
                        begin
                            wr_lanes[sel_lane] = 1'b1;
                            wr_addr = st.cm_sel[PAIR_W:1];
                            wr_data = {LANES{wb_dat_i[LANE_W-1:0]}};
                            next_st.ack = 1'b1;
                        end
                    end
                    else if (st.rd_wait)
                    begin
                        next_st.dat[LANE_W-1:0] =
                            rd_data[32'(sel_lane)*LANE_W +: LANE_W];
                        next_st.rd_wait = 1'b0;
                        next_st.ack = 1'b1;
                    end
                    else if (!rd_en)
                    begin
                        rd_en = 1'b1;
                        rd_addr = st.cm_sel[PAIR_W:1];
                        next_st.rd_wait = 1'b1;
                    end
                end
                REG_QUEUE:
                begin
                    if (!wb_we_i && st.cnt != '0)
                    begin
                        next_st.dat[QUEUE_VLD_BIT] = 1'b1;
                        next_st.dat[SLOT_W-1:0] = st.q[st.rp];
                        next_st.rp = st.rp + 1'b1;
                        next_st.cnt = st.cnt - 1'b1;
                    end
                    next_st.ack = 1'b1;
                end
                REG_STATUS:
                begin
                    next_st.dat[STAT_BUSY_BIT] = st.init_busy;
                    next_st.dat[STAT_OVF_BIT] = st.ovf;
                    if (!wb_we_i)
                        next_st.ovf = 1'b0;
                    next_st.ack = 1'b1;
                end
                default:
                    next_st.ack = 1'b1;
            endcase
        end

        // change address queue push; overflow set wins over clear
        if (push)
        begin
            if (next_st.cnt == (QPTR_W+1)'(QDEPTH))
                next_st.ovf = 1'b1;
            else
            begin
                next_st.q[st.wp] = st.p1.slot;
                next_st.wp = st.wp + 1'b1;
                next_st.cnt = next_st.cnt + 1'b1;
            end
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            st <= '0;
            st.hs_mode <= HS_RST;
            st.tri_lsb <= TRI_RST;
            st.period <= PERIOD_RST;
            st.init_busy <= 1'b1;
        end
        else
            st <= next_st;
    end

endmodule

// >>> verif/pdc_core_monitor.sv
// assertion checker for the pair handler ports
`timescale 1ns/1ps
module pdc_core_monitor
    import pdc_pkg::*;
(
    input wire logic         core_clk,   // clock
    input wire logic         reset,      // async reset
    input wire logic         wb_cyc_i,   // cycle
    input wire logic         wb_stb_i,   // strobe
    input wire logic         wb_we_i,    // write
    input wire logic [7:0]   wb_adr_i,   // address
    input wire logic         wb_ack_o,   // acknowledge
    input wire pdc_slot_t    slot_in,    // slot in
    input wire pdc_line_tx_t line_tx,    // line out
    input wire pdc_pcm_up_t  pcm_up,     // pcm out
    input wire pdc_mon_rx_t  mon_rx,     // monitor out
    input wire logic         change_irq  // queue not empty
);
    // =======================================================
    // clocking and slot sequences
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_slot;
        slot_in.valid;
    endsequence
    sequence s_even;
        slot_in.valid && !slot_in.slot[0];
    endsequence
    // =======================================================
    // assertions
    chk_slot_answer: assert property (s_slot
        |-> ##2 line_tx.valid && line_tx.slot == $past(slot_in.slot, 2))
        else $error("no line byte");
    chk_mon_even: assert property (s_even
        |-> ##2 mon_rx.valid && mon_rx.data == $past(slot_in.rx, 2))
        else $error("no monitor byte");
    chk_mon_odd: assert property (line_tx.valid
        && line_tx.slot[0] |-> !mon_rx.valid)
        else $error("monitor byte on odd slot");
    chk_pcm_odd: assert property (pcm_up.valid
        |-> line_tx.valid && line_tx.slot[0]) else $error("stray pcm byte");
    chk_irq_rise: assert property ($rose(change_irq)
        |-> line_tx.valid && line_tx.slot[0]) else $error("irq without slot");
    chk_irq_fall: assert property ($fell(change_irq)
        |-> $past(wb_cyc_i) && $past(wb_stb_i) && !$past(wb_we_i)
        && $past(wb_adr_i) == REG_QUEUE)
        else $error("irq fell without queue read");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o
        |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
endmodule

bind pdc_core pdc_core_monitor u_mon (.core_clk(core_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .slot_in(slot_in),
    .line_tx(line_tx), .pcm_up(pcm_up), .mon_rx(mon_rx),
    .change_irq(change_irq));

// >>> verif/pdc_line_model.sv
// line card and pcm highway model facing the pair handler
`timescale 1ns/1ps
module pdc_line_model
    import pdc_pkg::*;
(
    input  wire logic       core_clk,    // clock
    input  wire logic [7:0] pcm_dn_ptr,  // pcm lookup
    output      logic [7:0] pcm_dn_byte, // pcm byte
    output      logic       frame_start, // frame pulse
    output      pdc_slot_t  slot_in      // line slot
);
    // pcm byte per slot, two lsbs delivered at one
    assign pcm_dn_byte = {~pcm_dn_ptr[5:0], 2'b11};
    initial
    begin
        frame_start = 1'b0;
        slot_in = '0;
    end
    // one frame with one pair: even slot then odd slot
    task automatic send_pair(input logic [3:0] p, input logic [7:0] ro,
                             input logic [1:0] hs);
        @(posedge core_clk);
        frame_start <= 1'b1;
        @(posedge core_clk);
        frame_start <= 1'b0;
        slot_in <= {1'b1, p, 1'b0, ~ro, ro, hs};
        @(posedge core_clk);
        slot_in <= {1'b1, p, 1'b1, ro, ~ro, hs};
        @(posedge core_clk);
        slot_in <= {1'b0, 5'h0, ~ro, ro, ~hs}; // released: inverted
    endtask
endmodule

// >>> verif/test_pdc_core.sv
// self-checking bench for the preprocessed pair handler
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); n_fail++; end end
module test_pdc_core
    import pdc_pkg::*;
;
    logic         core_clk, reset, cyc, stb, we, frame_start, ack, irq;
    logic [7:0]   adr, pdn, pcm_b, ro, ptr_d, ptr_u, e;
    logic [31:0]  wdat, rdat, q, r;
    logic [3:0]   p, ci;
    logic [1:0]   hs, dd;
    logic [5:0]   s0, s1, sig;
    logic         chg;
    pdc_slot_t    slot_in;
    pdc_line_tx_t tx, ltx;
    pdc_pcm_up_t  up, lup;
    pdc_mon_rx_t  mon;
    int           n_fail, tests_run, cyc_cnt, n_up, nu, seed;

    pdc_core DUT (.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .frame_start(frame_start), .slot_in(slot_in), .pcm_dn_ptr(pdn),
        .pcm_dn_byte(pcm_b), .line_tx(tx), .pcm_up(up), .mon_rx(mon),
        .change_irq(irq));
    pdc_line_model lm (.core_clk(core_clk), .pcm_dn_ptr(pdn),
        .pcm_dn_byte(pcm_b), .frame_start(frame_start), .slot_in(slot_in));

    // =======================================================
    // clock, capture of odd slot answers, timeout
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc_cnt <= cyc_cnt + 1;
        if (tx.valid === 1'b1 && tx.slot[0] === 1'b1) ltx <= tx;
        if (up.valid === 1'b1)
        begin
            lup <= up;
            n_up <= n_up + 1;
        end
        if (cyc_cnt == 20000)
        begin
            n_fail++;
            end_of_test();
        end
    end
    // =======================================================
    // tasks
    function automatic logic [7:0] pcm(input logic [7:0] a);
        return {~a[5:0], 2'b11};
    endfunction
    task automatic end_of_test();
        if (n_fail == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge core_clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do
            @(posedge core_clk);
        while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic cm(input logic u, input logic o, input logic [3:0] c,
                      input logic [7:0] d);
        wb(1'b1, REG_CMSEL, {26'h0, u, p, o});
        wb(1'b1, REG_CMDATA, {20'h0, c, d});
    endtask
    task automatic frame();
        lm.send_pair(p, ro, hs);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic pop(input logic v);
        wb(1'b0, REG_QUEUE, 32'h0);
        `CHK("queue valid", v, q[8])
        if (v) `CHK("queue slot", {p, 1'b1}, q[4:0])
    endtask
    // =======================================================
    // main sequence
    initial
    begin
        {reset, cyc, stb, we, adr, wdat} = {1'b1, 43'h0};
        {n_fail, tests_run, cyc_cnt, n_up} = '0;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        seed = $urandom(32'habd2);
        wb(1'b0, REG_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h1, q)
        wb(1'b1, 8'h40, 32'hFF);
        wb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, q)
        p = 4'h0;
        cm(1'b0, 1'b0, CODE_SW64, 8'h55);
        wb(1'b1, REG_CMSEL, 32'h3F);
        wb(1'b0, REG_CMDATA, 32'h0);
        `CHK("cm swept", 32'h0, q)
        // central scheme, every 16 kbps pair code
        for (int k = 0; k < 4; k++)
        begin
            r = $urandom;
            {ptr_u, ptr_d, ro, dd, hs, ci} = r;
            p = 4'(r[3:0] % 15 + 1);
            cm(1'b0, 1'b0, CODE_SIGNAL, {2'b11, ci, 2'b11});
            cm(1'b0, 1'b1, {CODE_SW16_TOP, 2'(k)}, ptr_d);
            cm(1'b1, 1'b0, CODE_CI_UP, 8'hFF);
            cm(1'b1, 1'b1, {CODE_SW16_TOP, 2'(k)}, ptr_u);
            frame();
            e = pcm(ptr_d);
            `CHK("dn d bits", e[2*k+:2], ltx.data[7:6])
            `CHK("dn d oe", 2'b11, ltx.oe[7:6])
            `CHK("dn ci", {ci, hs}, ltx.data[5:0])
            `CHK("up ptr", ptr_u, lup.ptr)
            `CHK("up d bits", ro[7:6], lup.data[2*k+:2])
            chg = ro[5:2] !== 4'hF;
            `CHK("irq", chg, irq)
            pop(chg);
            frame();
            pop(1'b0);
        end
        // unassigned channel both ways, even entry back to code 1000
        nu = n_up;
        cm(1'b0, 1'b0, CODE_CI_UP, {2'b11, ci, 2'b11});
        cm(1'b0, 1'b1, CODE_DN_OFF, 8'h00);
        cm(1'b1, 1'b1, CODE_UNASSIGNED, 8'h00);
        frame();
        `CHK("d off", 2'b00, ltx.oe[7:6])
        `CHK("no pcm up", nu, n_up)
        // transparent 64 kbps, handshake and non-handshake
        cm(1'b1, 1'b0, CODE_UNASSIGNED, 8'h00);
        for (int m = 0; m < 2; m++)
        begin
            r = $urandom;
            {ptr_u, ptr_d, ro, dd, hs} = r[27:0];
            wb(1'b1, REG_CTRL, {30'h0, m[0], ~m[0]});
            cm(1'b0, 1'b0, CODE_CI_UP, {6'h3F, dd});
            cm(1'b0, 1'b1, CODE_SW64, ptr_d);
            cm(1'b1, 1'b1, CODE_SW64, ptr_u);
            frame();
            e = pcm(ptr_d);
            e[1:0] = e[1:0] & (m ? 2'b11 : hs);
            `CHK("64k dn", e, ltx.data)
            `CHK("64k up", ro, lup.data)
            `CHK("64k oe", m ? 8'hFC : 8'hFF, lup.oe)
        end
        // non-handshake ack positions come from the even entry
        cm(1'b0, 1'b1, CODE_DN_OFF, 8'h00);
        frame();
        `CHK("even acks", {4'hF, dd}, ltx.data[5:0])
        // six bit signaling, double last look
        wb(1'b1, REG_CTRL, 32'h1);
        r = $urandom;
        {sig, s0, hs} = r[13:0];
        s1 = s0 ^ 6'h15;
        ro = {s1, 2'b11};
        cm(1'b0, 1'b0, CODE_SIGNAL, {sig, 2'b11});
        cm(1'b0, 1'b1, CODE_DN_OFF, 8'h00);
        cm(1'b1, 1'b0, CODE_SIGNAL, {s0, 2'b00});
        cm(1'b1, 1'b1, CODE_SIGNAL, {s0, 2'b00});
        frame();
        `CHK("dn sig", {sig, hs}, ltx.data)
        pop(1'b0);
        frame();
        pop(1'b1);
        wb(1'b1, REG_CMSEL, {26'h0, 1'b1, p, 1'b1});
        wb(1'b0, REG_CMDATA, 32'h0);
        `CHK("stable sig", s1, q[7:2])
        // one sample every two frames: a change needs four frames
        wb(1'b1, REG_PERIOD, 32'h1);
        ro = {~s1, 2'b11};
        repeat (2) frame();
        pop(1'b0);
        repeat (2) frame();
        pop(1'b1);
        // software memory reset clears the selected entry
        wb(1'b1, REG_CTRL, 32'h5);
        do
            wb(1'b0, REG_STATUS, 32'h0);
        while (q[STAT_BUSY_BIT] === 1'b1);
        wb(1'b0, REG_CMDATA, 32'h0);
        `CHK("cm reset", 32'h0, q)
        end_of_test();
    end
endmodule
